/* File: rtl/fwp_feedback.sv */
`timescale 1ns/1ns
`include "fwp_params.svh"

module fwp_feedback (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire fwp_pkg::fwp_avmm_req_t avmm_req_in,
  output logic [`FWP_DATA_W-1:0]      avmm_readdata_out,
  output logic                        avmm_waitrequest_out,
  input  wire fwp_pkg::fwp_sync_fb_t  sync_fb_in,
  input  wire fwp_pkg::fwp_int_fb_t   int_fb_in,
  output fwp_pkg::fwp_table_t         table_entry_out
);
  import fwp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [`FWP_INT_W-1:0] len_mask(
    input logic [`FWP_LEN_W-1:0] len
  );
    len_mask = (32'h1 << len) - 32'h1;
  endfunction

  function automatic fwp_path_t src_path(input fwp_src_t src);
    unique case (src)
      FWP_SRC_A, FWP_SRC_LEG_REG: src_path = FWP_PATH_A;
      FWP_SRC_B, FWP_SRC_LEG_DEC: src_path = FWP_PATH_B;
      FWP_SRC_INT_PROC:           src_path = FWP_PATH_INT;
      default:                    src_path = FWP_PATH_BAD;
    endcase
  endfunction

  function automatic logic src_is_sync(input fwp_src_t src);
    src_is_sync = (src == FWP_SRC_SYNC_RAW) || (src == FWP_SRC_A) ||
                  (src == FWP_SRC_B) || (src == FWP_SRC_LEG_REG) ||
                  (src == FWP_SRC_LEG_DEC);
  endfunction

  function automatic logic cfg_ok(input fwp_path_t path, input fwp_cfg_t c);
    logic [`FWP_SHIFT_W-1:0] smax;
    smax = (path == FWP_PATH_INT) ? `FWP_INT_SHIFT_MAX
                                  : `FWP_SYNC_SHIFT_MAX;
    cfg_ok = (path != FWP_PATH_BAD) && (c.shift <= smax) &&
             (c.length >= `FWP_LEN_MIN) &&
             (c.length <= `FWP_LEN_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  fwp_state_t              state_q;
  logic [3:0]              cnt_q;
  fwp_cfg_t                cfg_q [0:2];
  logic [2:0]              configured_q;
  logic [`FWP_SYNC_W-1:0]  sync_word_q;
  logic [`FWP_INT_W-1:0]   int_word_q;
  logic [`FWP_INT_W-1:0]   int_word_d;
  logic                    msd_q;
  logic                    cfg_err_q;
  logic                    src_err_q;
  logic [`FWP_DATA_W-1:0]  result_q;
  logic [`FWP_DATA_W-1:0]  readdata_q;
  fwp_table_t              table_q;
  logic [`FWP_INT_W-1:0]   snap_word_q;
  fwp_cfg_t                snap_cfg_q;
  fwp_src_t                snap_src_q;
  logic                    snap_proc_q;
  logic                    snap_table_q;
  logic                    snap_bad_q;

  logic                    req_any;
  logic                    cfg_wr;
  logic                    op_wr;
  logic                    stat_wr;
  logic                    ctrl_wr;
  logic                    ack;
  fwp_path_t               cfg_path;
  fwp_cfg_t                cfg_new;
  fwp_src_t                req_src;
  fwp_path_t               req_path;
  logic [`FWP_INT_W-1:0]   proc_value;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req_any  = avmm_req_in.read | avmm_req_in.write;
  assign cfg_wr   = avmm_req_in.write &
                    (avmm_req_in.address == `FWP_ADDR_CONFIG);
  assign op_wr    = avmm_req_in.write &
                    (avmm_req_in.address == `FWP_ADDR_REQUEST);
  assign stat_wr  = avmm_req_in.write &
                    (avmm_req_in.address == `FWP_ADDR_STATUS);
  assign ctrl_wr  = avmm_req_in.write &
                    (avmm_req_in.address == `FWP_ADDR_CONTROL);
  assign ack      = (state_q == FWP_ST_ACK);

  assign cfg_path = fwp_path_t'(
    avmm_req_in.writedata[`FWP_CFG_PATH_HI:`FWP_CFG_PATH_LO]);
  assign cfg_new.shift  =
    avmm_req_in.writedata[`FWP_CFG_SHIFT_HI:`FWP_CFG_SHIFT_LO];
  assign cfg_new.length =
    avmm_req_in.writedata[`FWP_CFG_LEN_HI:`FWP_CFG_LEN_LO];
  assign cfg_new.offset =
    avmm_req_in.writedata[`FWP_CFG_OFF_HI:`FWP_CFG_OFF_LO];

  assign req_src  = fwp_src_t'(
    avmm_req_in.writedata[`FWP_REQ_SRC_HI:`FWP_REQ_SRC_LO]);
  assign req_path = src_path(req_src);

  assign avmm_waitrequest_out = req_any & ~ack;
  assign avmm_readdata_out    = readdata_q;
  assign table_entry_out      = table_q;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= FWP_ST_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        FWP_ST_IDLE: begin
          if (cfg_wr) begin
            state_q <= FWP_ST_CFG;
            cnt_q   <= `FWP_CFG_CYCLES - 4'h1;
          end else if (op_wr) begin
            state_q <= FWP_ST_CAP;
          end else if (req_any) begin
            state_q <= FWP_ST_ACK;
          end
        end
        FWP_ST_CFG: begin
          if (cnt_q == 4'h0) begin
            state_q <= FWP_ST_ACK;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        FWP_ST_CAP: state_q <= FWP_ST_CMP;
        FWP_ST_CMP: state_q <= FWP_ST_ACK;
        FWP_ST_ACK: state_q <= FWP_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback word capture

  genvar g;
  generate
    for (g = 0; g < `FWP_INT_W / 2; g++) begin : gen_pair
      assign int_word_d[2*g]   = int_fb_in.word[2*g];
      assign int_word_d[2*g+1] = msd_q & int_fb_in.word[2*g+1];
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync_word_q <= 16'h0000;
      int_word_q  <= 32'h0000_0000;
    end else begin
      if (sync_fb_in.valid) begin
        sync_word_q <= sync_fb_in.word;
      end
      if (int_fb_in.valid) begin
        int_word_q <= int_word_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Path parameters

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 3; i++) begin
        cfg_q[i] <= '0;
      end
      configured_q <= 3'b000;
    end else if (ack && cfg_wr && cfg_ok(cfg_path, cfg_new)) begin
      cfg_q[cfg_path[1:0]]        <= cfg_new;
      configured_q[cfg_path[1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      msd_q <= 1'b0;
    end else if (ack && ctrl_wr) begin
      msd_q <= avmm_req_in.writedata[`FWP_CTRL_MSD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags, set wins over clear

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_err_q <= 1'b0;
      src_err_q <= 1'b0;
    end else begin
      if (ack && stat_wr &&
          avmm_req_in.writedata[`FWP_STAT_CFG_ERR]) begin
        cfg_err_q <= 1'b0;
      end
      if (ack && stat_wr &&
          avmm_req_in.writedata[`FWP_STAT_SRC_ERR]) begin
        src_err_q <= 1'b0;
      end
      if (ack && cfg_wr && !cfg_ok(cfg_path, cfg_new)) begin
        cfg_err_q <= 1'b1;
      end
      if (state_q == FWP_ST_CMP && snap_bad_q) begin
        src_err_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation snapshot and compute

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      snap_word_q  <= 32'h0000_0000;
      snap_cfg_q   <= '0;
      snap_src_q   <= FWP_SRC_SYNC_RAW;
      snap_proc_q  <= 1'b0;
      snap_table_q <= 1'b0;
      snap_bad_q   <= 1'b0;
    end else if (state_q == FWP_ST_CAP) begin
      snap_word_q  <= src_is_sync(req_src) ? {16'h0000, sync_word_q}
                                           : int_word_q;
      snap_cfg_q   <= (req_path != FWP_PATH_BAD) ? cfg_q[req_path[1:0]]
                                                 : '0;
      snap_src_q   <= req_src;
      snap_proc_q  <= (req_path != FWP_PATH_BAD) &&
                      configured_q[req_path[1:0]];
      snap_table_q <= avmm_req_in.writedata[`FWP_REQ_TABLE_BIT];
      snap_bad_q   <= (req_src == FWP_SRC_BAD) ||
                      (avmm_req_in.writedata[`FWP_REQ_TABLE_BIT] &&
                       req_src == FWP_SRC_INT_RAW);
    end
  end

  assign proc_value = ((snap_word_q >> snap_cfg_q.shift) &
                       len_mask(snap_cfg_q.length)) +
                      {20'h00000, snap_cfg_q.offset};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      result_q <= 32'h0000_0000;
      table_q  <= '0;
    end else begin
      table_q.valid <= 1'b0;
      if (state_q == FWP_ST_CMP && !snap_bad_q) begin
        result_q <= snap_proc_q ? proc_value : snap_word_q;
        if (snap_table_q) begin
          table_q.valid <= 1'b1;
          table_q.index <= snap_proc_q ? proc_value : snap_word_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      readdata_q <= 32'h0000_0000;
    end else if (state_q == FWP_ST_IDLE && avmm_req_in.read) begin
      unique case (avmm_req_in.address)
        `FWP_ADDR_RESULT:    readdata_q <= result_q;
        `FWP_ADDR_STATUS:    readdata_q <= {26'h0000000, src_err_q,
                                            cfg_err_q, 1'b0, configured_q};
        `FWP_ADDR_CONTROL:   readdata_q <= {31'h00000000, msd_q};
        `FWP_ADDR_SYNC_WORD: readdata_q <= {16'h0000, sync_word_q};
        `FWP_ADDR_INT_WORD:  readdata_q <= int_word_q;
        default:             readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  cfg_block_a: assert property (
    (state_q == FWP_ST_IDLE && cfg_wr) |=>
      (state_q == FWP_ST_CFG)[*4] ##1 (state_q == FWP_ST_ACK))
    else $error("config access not held for four cycles");

  op_latency_a: assert property (
    (state_q == FWP_ST_IDLE && op_wr) |=>
      state_q == FWP_ST_CAP ##1 state_q == FWP_ST_CMP
      ##1 state_q == FWP_ST_ACK)
    else $error("feedback operation latency wrong");

  raw_pass_a: assert property (
    (state_q == FWP_ST_CMP && !snap_bad_q &&
     snap_src_q == FWP_SRC_SYNC_RAW) |=>
      result_q == {16'h0000, $past(sync_word_q, 2)} ||
      $past(sync_fb_in.valid, 2))
    else $error("raw sync result differs from word");

  unconfig_pass_a: assert property (
    (state_q == FWP_ST_CMP && !snap_bad_q && !snap_proc_q) |=>
      result_q == $past(snap_word_q))
    else $error("unconfigured path altered the word");

  proc_math_a: assert property (
    (state_q == FWP_ST_CMP && !snap_bad_q && snap_proc_q) |=>
      result_q - {20'h00000, $past(snap_cfg_q.offset)} ==
      (($past(snap_word_q) >> $past(snap_cfg_q.shift)) &
       len_mask($past(snap_cfg_q.length))))
    else $error("processed result wrong");

  table_raw_a: assert property (
    (state_q == FWP_ST_CMP && snap_table_q &&
     snap_src_q == FWP_SRC_INT_RAW) |=> !table_q.valid && src_err_q)
    else $error("internal raw path reached table playback");

  table_pulse_a: assert property (
    table_q.valid |-> $past(state_q == FWP_ST_CMP) ##1 !table_q.valid)
    else $error("table entry strobe not a single pulse");

  bad_length_a: assert property (
    (ack && cfg_wr && (cfg_new.length == 5'd0 ||
                       cfg_new.length > 5'd16)) |=>
      configured_q == $past(configured_q) && cfg_err_q)
    else $error("illegal length accepted");

  legacy_alias_a: assert property (
    (state_q == FWP_ST_CAP && req_src == FWP_SRC_LEG_DEC) |=>
      snap_cfg_q == $past(cfg_q[1]) && snap_proc_q == $past(configured_q[1]))
    else $error("legacy decoder source not aliased to path B");

  msd_pairs_a: assert property (
    (int_fb_in.valid && !msd_q) |=> (int_word_q & 32'haaaa_aaaa) == 32'h0)
    else $error("upper pair bits kept without multistate mode");

  cfg_then_table_c: cover property (
    (ack && cfg_wr && cfg_ok(cfg_path, cfg_new)) ##[1:20] table_q.valid);
  processed_table_c: cover property (table_q.valid && snap_proc_q);
  source_error_c: cover property ($rose(src_err_q));
  config_error_c: cover property ($rose(cfg_err_q));

endmodule // fwp_feedback

/* File: pkg/fwp_params.svh */
`ifndef FWP_PARAMS_SVH
`define FWP_PARAMS_SVH

// Register byte addresses
`define FWP_ADDR_CONFIG     8'h00
`define FWP_ADDR_REQUEST    8'h04
`define FWP_ADDR_RESULT     8'h08
`define FWP_ADDR_STATUS     8'h0c
`define FWP_ADDR_CONTROL    8'h10
`define FWP_ADDR_SYNC_WORD  8'h14
`define FWP_ADDR_INT_WORD   8'h18

// Field widths
`define FWP_ADDR_W          8
`define FWP_DATA_W          32
`define FWP_SYNC_W          16
`define FWP_INT_W           32
`define FWP_SHIFT_W         5
`define FWP_LEN_W           5
`define FWP_OFFSET_W        12

// Configuration word fields
`define FWP_CFG_PATH_HI     31
`define FWP_CFG_PATH_LO     30
`define FWP_CFG_SHIFT_HI    28
`define FWP_CFG_SHIFT_LO    24
`define FWP_CFG_LEN_HI      20
`define FWP_CFG_LEN_LO      16
`define FWP_CFG_OFF_HI      11
`define FWP_CFG_OFF_LO      0

// Request word fields
`define FWP_REQ_SRC_HI      2
`define FWP_REQ_SRC_LO      0
`define FWP_REQ_TABLE_BIT   8

// Status and control bits
`define FWP_STAT_CFG_ERR    4
`define FWP_STAT_SRC_ERR    5
`define FWP_CTRL_MSD_BIT    0

// Limits
`define FWP_SYNC_SHIFT_MAX  5'd15
`define FWP_INT_SHIFT_MAX   5'd31
`define FWP_LEN_MIN         5'd1
`define FWP_LEN_MAX         5'd16

// Cycles a configuration write holds the sequencer in FWP_ST_CFG before the acknowledge
`define FWP_CFG_CYCLES      4'd4

`endif

/* File: pkg/fwp_pkg.sv */
`include "fwp_params.svh"

package fwp_pkg;

  typedef enum logic [1:0] {
    FWP_PATH_A, FWP_PATH_B, FWP_PATH_INT, FWP_PATH_BAD
  } fwp_path_t;

  typedef enum logic [2:0] {
    FWP_SRC_SYNC_RAW, FWP_SRC_A, FWP_SRC_B, FWP_SRC_INT_RAW,
    FWP_SRC_INT_PROC, FWP_SRC_LEG_REG, FWP_SRC_LEG_DEC, FWP_SRC_BAD
  } fwp_src_t;

  typedef enum {
    FWP_ST_IDLE, FWP_ST_CFG, FWP_ST_CAP, FWP_ST_CMP, FWP_ST_ACK
  } fwp_state_t;

  typedef struct packed {
    logic [`FWP_SHIFT_W-1:0]  shift;
    logic [`FWP_LEN_W-1:0]    length;
    logic [`FWP_OFFSET_W-1:0] offset;
  } fwp_cfg_t;

  typedef struct packed {
    logic                   read;
    logic                   write;
    logic [`FWP_ADDR_W-1:0] address;
    logic [`FWP_DATA_W-1:0] writedata;
  } fwp_avmm_req_t;

  typedef struct packed {
    logic                   valid;
    logic [`FWP_SYNC_W-1:0] word;
  } fwp_sync_fb_t;

  typedef struct packed {
    logic                  valid;
    logic [`FWP_INT_W-1:0] word;
  } fwp_int_fb_t;

  typedef struct packed {
    logic                  valid;
    logic [`FWP_INT_W-1:0] index;
  } fwp_table_t;

endpackage

/* File: verification/fwp_fb_source.sv */
`timescale 1ns/1ns
module fwp_fb_source (
  input  wire logic             clk_in,
  input  wire logic             send_sync_in,
  input  wire logic [15:0]      sync_word_in,
  input  wire logic             send_int_in,
  input  wire logic [31:0]      int_word_in,
  output fwp_pkg::fwp_sync_fb_t sync_fb_out,
  output fwp_pkg::fwp_int_fb_t  int_fb_out
);
  import fwp_pkg::*;

  initial begin
    sync_fb_out = '0;
    int_fb_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle words, scrambled while idle
  always @(posedge clk_in) begin
    sync_fb_out.valid <= send_sync_in;
    if (send_sync_in) begin
      sync_fb_out.word <= sync_word_in;
    end else begin
      sync_fb_out.word <= ~sync_fb_out.word;
    end
    int_fb_out.valid <= send_int_in;
    if (send_int_in) begin
      int_fb_out.word <= int_word_in;
    end else begin
      int_fb_out.word <= ~int_fb_out.word;
    end
  end
endmodule // fwp_fb_source

/* File: verification/test_feedback_word_processing.sv */
`timescale 1ns/1ns
`include "fwp_params.svh"
module test_feedback_word_processing;
  import fwp_pkg::*;
  logic          clk_in;
  logic          reset_in;
  fwp_avmm_req_t req;
  logic [31:0]   rdata;
  logic          wait_req;
  fwp_sync_fb_t  sync_fb;
  fwp_int_fb_t   int_fb;
  fwp_table_t    tbl;
  logic          send_sync;
  logic          send_int;
  logic [15:0]   sync_word;
  logic [31:0]   int_word;
  int            fail_count;
  int            n_tests;
  int            ncyc;
  logic [31:0]   q;
  fwp_table_t    tq;

  fwp_feedback i_dut (
    .clk_in              (clk_in),
    .reset_in            (reset_in),
    .avmm_req_in         (req),
    .avmm_readdata_out   (rdata),
    .avmm_waitrequest_out(wait_req),
    .sync_fb_in          (sync_fb),
    .int_fb_in           (int_fb),
    .table_entry_out     (tbl)
  );

  fwp_fb_source i_src (
    .clk_in      (clk_in),
    .send_sync_in(send_sync),
    .sync_word_in(sync_word),
    .send_int_in (send_int),
    .int_word_in (int_word),
    .sync_fb_out (sync_fb),
    .int_fb_out  (int_fb)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    ncyc = 0;
    do begin
      @(posedge clk_in);
      ncyc++;
    end while (wait_req !== 1'b0);
    q = rdata;
    tq = tbl;
    req <= '0;
  endtask

  task send(input logic [15:0] s, input logic [31:0] i);
    @(posedge clk_in);
    send_sync <= 1'b1;
    send_int <= 1'b1;
    sync_word <= s;
    int_word <= i;
    @(posedge clk_in);
    send_sync <= 1'b0;
    send_int <= 1'b0;
  endtask

  task fetch(input logic [2:0] src, input logic [31:0] exp);
    bus(1'b1, `FWP_ADDR_REQUEST, {29'h0, src});
    bus(1'b0, `FWP_ADDR_RESULT, 32'h0);
    check_word(q, exp);
  endtask

  task cfg(input logic [1:0] p, input logic [4:0] s, input logic [4:0] l,
           input logic [11:0] o);
    bus(1'b1, `FWP_ADDR_CONFIG, {p, 1'b0, s, 3'h0, l, 4'h0, o});
  endtask

  function automatic logic [31:0] proc(input logic [31:0] w,
      input logic [4:0] s, input logic [4:0] l, input logic [11:0] o);
    return ((w >> s) & ((32'h1 << l) - 32'h1)) + {20'h0, o};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset_vals;
    bus(1'b0, `FWP_ADDR_STATUS, 32'h0);
    check_word(q, 32'h0);
    bus(1'b0, `FWP_ADDR_CONTROL, 32'h0);
    check_word(q, 32'h0);
    bus(1'b1, 8'h1c, 32'hffffffff);
    check_word(32'(ncyc), 32'h2);
    bus(1'b0, 8'h1c, 32'h0);
    check_word(q, 32'h0);
  endtask

  task t_unconf;
    logic [2:0] srcs [5];
    srcs = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    send(16'ha5c3, 32'hdeadbeef);
    bus(1'b0, `FWP_ADDR_SYNC_WORD, 32'h0);
    check_word(q, 32'h0000a5c3);
    foreach (srcs[k]) fetch(srcs[k], 32'h0000a5c3);
    fetch(3'h3, 32'hdeadbeef & 32'h55555555);
    fetch(3'h4, 32'hdeadbeef & 32'h55555555);
  endtask

  task t_config;
    logic [31:0] wi;
    wi = 32'hdeadbeef & 32'h55555555;
    cfg(2'h0, 5'd4, 5'd3, 12'h100);
    check_word(32'(ncyc), 32'h6);
    cfg(2'h1, 5'd15, 5'd1, 12'hfff);
    cfg(2'h2, 5'd31, 5'd16, 12'h007);
    bus(1'b0, `FWP_ADDR_STATUS, 32'h0);
    check_word(q, 32'h7);
    fetch(3'h1, proc(32'ha5c3, 5'd4, 5'd3, 12'h100));
    fetch(3'h5, proc(32'ha5c3, 5'd4, 5'd3, 12'h100));
    fetch(3'h2, proc(32'ha5c3, 5'd15, 5'd1, 12'hfff));
    fetch(3'h6, proc(32'ha5c3, 5'd15, 5'd1, 12'hfff));
    fetch(3'h0, 32'h0000a5c3);
    fetch(3'h4, proc(wi, 5'd31, 5'd16, 12'h007));
  endtask

  task t_table;
    bus(1'b1, `FWP_ADDR_REQUEST, 32'h101);
    check_word(32'(ncyc), 32'h4);
    check_word({31'h0, tq.valid}, 32'h1);
    check_word(tq.index, proc(32'ha5c3, 5'd4, 5'd3, 12'h100));
    bus(1'b1, `FWP_ADDR_REQUEST, 32'h103);
    check_word({31'h0, tq.valid}, 32'h0);
    bus(1'b0, `FWP_ADDR_STATUS, 32'h0);
    check_word(q & 32'h30, 32'h20);
    bus(1'b1, `FWP_ADDR_STATUS, 32'h30);
    bus(1'b0, `FWP_ADDR_STATUS, 32'h0);
    check_word(q & 32'h30, 32'h0);
    bus(1'b1, `FWP_ADDR_REQUEST, 32'h107);
    check_word({31'h0, tq.valid}, 32'h0);
    bus(1'b0, `FWP_ADDR_STATUS, 32'h0);
    check_word(q & 32'h30, 32'h20);
    bus(1'b1, `FWP_ADDR_STATUS, 32'h20);
  endtask

  task t_refuse;
    logic [23:0] bad [4];
    bad = '{{2'h0, 5'd16, 5'd3, 12'h0}, {2'h0, 5'd4, 5'd0, 12'h0},
            {2'h0, 5'd4, 5'd17, 12'h0}, {2'h3, 5'd4, 5'd3, 12'h0}};
    foreach (bad[k]) begin
      cfg(bad[k][23:22], bad[k][21:17], bad[k][16:12], bad[k][11:0]);
      bus(1'b0, `FWP_ADDR_STATUS, 32'h0);
      check_word(q & 32'h10, 32'h10);
      bus(1'b1, `FWP_ADDR_STATUS, 32'h10);
    end
    fetch(3'h1, proc(32'ha5c3, 5'd4, 5'd3, 12'h100));
  endtask

  task t_reconf;
    cfg(2'h0, 5'd1, 5'd12, 12'h0);
    fetch(3'h1, proc(32'ha5c3, 5'd1, 5'd12, 12'h0));
    send(16'h1234, 32'h0);
    fetch(3'h1, proc(32'h1234, 5'd1, 5'd12, 12'h0));
  endtask

  task t_msd;
    bus(1'b1, `FWP_ADDR_CONTROL, 32'h1);
    bus(1'b0, `FWP_ADDR_CONTROL, 32'h0);
    check_word(q, 32'h1);
    send(16'h0, 32'hf0f0a5a5);
    bus(1'b0, `FWP_ADDR_INT_WORD, 32'h0);
    check_word(q, 32'hf0f0a5a5);
    fetch(3'h3, 32'hf0f0a5a5);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    reset_in = 1'b1;
    req = '0;
    send_sync = 1'b0;
    send_int = 1'b0;
    sync_word = 16'h0;
    int_word = 32'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset_vals;
    t_unconf;
    t_config;
    t_table;
    t_refuse;
    t_reconf;
    t_msd;
    give_verdict;
  end

  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
endmodule // test_feedback_word_processing
